/* isu_pkg.sv */
// Purpose: Shared constants and carriers for the interrupt sequencing unit
// Assumes: APB with 32-bit data, 16-bit byte addresses
// Notes:   Source index 1 is the lowest priority, 6 the highest
package isu_pkg;

  // ==========================================================
  // Register map
  localparam logic [15:0] PEND_STATUS_ONE_ADDR = 16'hfe04;
  localparam logic [15:0] EVT_STATUS_ADDR      = 16'hfe08;
  localparam logic [15:0] EVT_MASK_ADDR        = 16'hfe0c;
  localparam logic [7:0]  PEND_STATUS_ONE_RST  = 8'h00;
  localparam logic [2:0]  EVT_STATUS_RST       = 3'h0;
  localparam logic [2:0]  EVT_MASK_RST         = 3'h0;

  // ==========================================================
  // Field layout
  localparam int          FLAG_LSB    = 2;
  localparam int          NUM_SRC     = 6;
  localparam int          EVT_HW      = 0;
  localparam int          EVT_SWI     = 1;
  localparam int          EVT_CHAIN   = 2;
  localparam logic [1:0]  LOW_BITS    = 2'h0;
  localparam logic [2:0]  NO_SRC      = 3'h0;
  localparam logic [15:0] PC_HW_ADJ   = 16'h0001;

  // ==========================================================
  // Carriers
  typedef enum logic [2:0] {
    ISU_RUN, ISU_ENTRY, ISU_SERVICE, ISU_RETURN
  } isu_state_e;

  typedef struct packed {
    logic        instr_done;   // Current instruction completed
    logic        swi_exec;     // Software trap decoded
    logic        rti_done;     // Return restored the registers
    logic        stack_done;   // Stacking and vector fetch finished
    logic        i_mask;       // Global mask bit, live
    logic [15:0] pc;           // Address of next opcode
  } isu_cpu_s;

  typedef struct packed {
    logic        enter;        // Start interrupt entry
    logic        software_trap_instruction;          // Entry is the software trap
    logic [2:0]  vector_sel;   // Winning source, 0 for trap
    logic [15:0] stack_pc;     // Value to push as return address
    logic        save_regs;    // Push processor registers
    logic        push_h;       // Index high register push, never set
    logic        set_i;        // Set global mask
    logic        prefetch;     // Prefetch next program opcode
    logic        fetch_next;   // Run next instruction
  } isu_seq_s;

endpackage

/* isu_top.sv */
// Purpose: Interrupt sequencing unit of the system integration unit
// Assumes: Request lines are asynchronous; CPU strobes are on pclk
// Notes:   Single clock; APB slave answers with one wait-free access
//
// Functional notes
// - Never abort a running instruction; start only after it completes.
// - At completion take a request only if mask clear and source enabled.
// - Of several pending requests service the highest priority first.
// - A request pending at return is serviced before the next instruction.
// - Return always prefetches the next opcode, even if redundant.
// - Interrupt entry never stacks the index high register.
// - Software trap always interrupts, whatever the global mask.
// - Trap stacks the program counter; hardware stacks it minus one.
// - Status register bits 7..2 show live request flags for six sources.
// - Status bits 1..0 read zero, writes ignored, reset value zero.
// - Entry saves processor registers and sets the global mask.
// - A latched request holds precedence until serviced or mask cleared; here requests are not latched and are re-arbitrated live at each boundary.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module isu_top (
  input  wire logic             pclk,        // Bus clock, 250 MHz
  input  wire logic             presetn,     // Async reset, active low
  input  wire logic             psel,        // APB select
  input  wire logic             penable,     // APB access phase
  input  wire logic             pwrite,      // APB write
  input  wire logic [15:0]      paddr,       // APB byte address
  input  wire logic [31:0]      pwdata,      // APB write data
  output logic      [31:0]      prdata,      // APB read data
  output logic                  pready,      // APB ready
  output logic                  pslverr,     // APB error, unmapped address
  input  wire logic [6:1]       req_line,    // Peripheral requests, async
  input  wire logic [6:1]       src_enable,  // Per-source enables
  input  isu_pkg::isu_cpu_s     cpu,         // Core status strobes
  output isu_pkg::isu_seq_s     seq,         // Sequencing commands to core
  output logic                  irq          // Event interrupt, level
);

  // ==========================================================
  // Request synchroniser
  logic [6:1] req_meta;
  logic [6:1] req_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_meta <= '0;
      req_sync <= '0;
    end else begin
      req_meta <= req_line;
      req_sync <= req_meta;
    end
  end

  // Highest index wins; returns 0 when nothing qualifies
  function automatic logic [2:0] isu_pick(input logic [6:1] pend);
    logic [2:0] win;
    win = isu_pkg::NO_SRC;
    for (int i = 1; i <= isu_pkg::NUM_SRC; i++) begin
      if (pend[i]) begin
        win = 3'(i);
      end
    end
    return win;
  endfunction

  // ==========================================================
  // Sequencer
  isu_pkg::isu_state_e state;
  logic [6:1]          eligible;
  logic [2:0]          winner;
  logic                hw_taken;
  logic                swi_taken;

  assign eligible  = (cpu.i_mask) ? 6'h00 : (req_sync & src_enable);
  assign winner    = isu_pick(eligible);
  // Boundaries: instruction completion, or a completed return
  assign swi_taken = (state == isu_pkg::ISU_RUN) && cpu.instr_done
                     && cpu.swi_exec;
  assign hw_taken  = !swi_taken && (winner != isu_pkg::NO_SRC)
                     && (((state == isu_pkg::ISU_RUN) && cpu.instr_done)
                         || (state == isu_pkg::ISU_RETURN));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= isu_pkg::ISU_RUN;
    end else begin
      case (state)
        isu_pkg::ISU_RUN: begin
          if (swi_taken || hw_taken) begin
            state <= isu_pkg::ISU_ENTRY;
          end
        end
        isu_pkg::ISU_ENTRY: begin
          // No arbitration until return, so the entered source keeps precedence
          if (cpu.stack_done) begin
            state <= isu_pkg::ISU_SERVICE;
          end
        end
        isu_pkg::ISU_SERVICE: begin
          if (cpu.rti_done) begin
            state <= isu_pkg::ISU_RETURN;
          end
        end
        isu_pkg::ISU_RETURN: begin
          state <= hw_taken ? isu_pkg::ISU_ENTRY : isu_pkg::ISU_RUN;
        end
        default: begin
          state <= isu_pkg::ISU_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // Command outputs to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= '0;
    end else begin
      seq.enter      <= swi_taken || hw_taken;
      seq.save_regs  <= swi_taken || hw_taken;
      seq.set_i      <= swi_taken || hw_taken;
      seq.push_h     <= 1'b0;
      // Return prefetch is issued even when another entry follows
      seq.prefetch   <= (state == isu_pkg::ISU_RETURN);
      seq.fetch_next <= ((state == isu_pkg::ISU_RUN) && cpu.instr_done
                         && !swi_taken && !hw_taken);
      if (swi_taken) begin
        seq.software_trap_instruction        <= 1'b1;
        seq.vector_sel <= isu_pkg::NO_SRC;
        seq.stack_pc   <= cpu.pc;
      end else if (hw_taken) begin
        seq.software_trap_instruction        <= 1'b0;
        seq.vector_sel <= winner;
        seq.stack_pc   <= cpu.pc - isu_pkg::PC_HW_ADJ;
      end
    end
  end

  // ==========================================================
  // Registers and event interrupt
  logic [7:0] pend_status;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic [2:0] evt_set;
  logic       setup;
  logic       wr_acc;
  logic       mapped;

  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pready && pwrite;
  assign evt_set[isu_pkg::EVT_HW]    = hw_taken;
  assign evt_set[isu_pkg::EVT_SWI]   = swi_taken;
  assign evt_set[isu_pkg::EVT_CHAIN] = (state == isu_pkg::ISU_RETURN) && hw_taken;
  assign mapped  = (paddr == isu_pkg::PEND_STATUS_ONE_ADDR)
                   || (paddr == isu_pkg::EVT_STATUS_ADDR)
                   || (paddr == isu_pkg::EVT_MASK_ADDR);

  // Live copy of requests; no write path reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_status <= isu_pkg::PEND_STATUS_ONE_RST;
    end else begin
      pend_status <= {req_sync, isu_pkg::LOW_BITS};
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= isu_pkg::EVT_STATUS_RST;
    end else if (wr_acc && paddr == isu_pkg::EVT_STATUS_ADDR) begin
      evt_status <= (evt_status & ~pwdata[2:0]) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask <= isu_pkg::EVT_MASK_RST;
    end else if (wr_acc && paddr == isu_pkg::EVT_MASK_ADDR) begin
      evt_mask <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

  // ==========================================================
  // APB slave: read data captured in setup, ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        case (paddr)
          isu_pkg::PEND_STATUS_ONE_ADDR: prdata <= {24'h000000, pend_status};
          isu_pkg::EVT_STATUS_ADDR:      prdata <= {29'h00000000, evt_status};
          isu_pkg::EVT_MASK_ADDR:        prdata <= {29'h00000000, evt_mask};
          default:                       prdata <= '0;
        endcase
      end else begin
        prdata <= '0;
      end
    end
  end

endmodule

/* isu_chk_assertions.sv */
// Purpose: Port checks for isu_top
// Assumes: One clock domain
// Notes:   Bound at the foot
`timescale 1ns/1ns
module isu_chk (
  input wire logic         pclk,       // Clock
  input wire logic         presetn,    // Reset
  input wire logic         psel,       // Select
  input wire logic         penable,    // Access
  input wire logic         pwrite,     // Write
  input wire logic [15:0]  paddr,      // Address
  input wire logic [31:0]  pwdata,     // Wdata
  input wire logic [31:0]  prdata,     // Rdata
  input wire logic         pready,     // Ready
  input wire logic         pslverr,    // Error
  input wire logic [6:1]   req_line,   // Requests
  input wire logic [6:1]   src_enable, // Enables
  input isu_pkg::isu_cpu_s cpu,        // Core
  input isu_pkg::isu_seq_s seq,        // Commands
  input wire logic         irq         // Irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Idle tracking, late by a cycle to stay safe
  logic in_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) in_run <= 1'b1;
    else if (seq.enter) in_run <= 1'b0;
    else if (seq.prefetch) in_run <= 1'b1;
  end
  wire hw_done = in_run && cpu.instr_done && !cpu.swi_exec;
  sequence trap_s; in_run && cpu.instr_done && cpu.swi_exec; endsequence
  sequence trap_in_s; seq.enter && seq.software_trap_instruction && seq.vector_sel == 3'h0; endsequence
  // ==========================================
  // Checks
  chk_trap_entry: assert property (trap_s |=> trap_in_s ##0 seq.stack_pc == $past(cpu.pc))
    else $error("Trap entry wrong");
  chk_hw_stack_pc: assert property (hw_done |=> (seq.enter |-> !seq.software_trap_instruction
    && seq.stack_pc == $past(cpu.pc) - 16'h0001))
    else $error("Hardware stacked value wrong");
  chk_mask_blocks: assert property (hw_done && cpu.i_mask |=> !seq.enter && seq.fetch_next)
    else $error("Masked request taken");
  chk_entry_pulses: assert property (seq.enter |-> seq.save_regs && seq.set_i ##1 !seq.enter)
    else $error("Entry pulses wrong");
  chk_return_prefetch: assert property (cpu.rti_done |-> ##[1:3] seq.prefetch)
    else $error("No prefetch on return");
  chk_no_high_push: assert property (!seq.push_h)
    else $error("Index high pushed");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("Ready not one cycle");
  chk_status_zero: assert property (pready && !pwrite && paddr == isu_pkg::PEND_STATUS_ONE_ADDR
    |-> prdata[1:0] == isu_pkg::LOW_BITS && prdata[31:8] == 24'h0)
    else $error("Status fixed bits wrong");
  chk_entry_cause: assert property (seq.enter |-> $past(cpu.instr_done) || seq.prefetch)
    else $error("Entry without boundary");
  chk_no_reentry: assert property (!in_run |-> !seq.enter || seq.prefetch)
    else $error("Entry during service");
endmodule
bind isu_top isu_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .req_line(req_line), .src_enable(src_enable), .cpu(cpu), .seq(seq),
  .irq(irq));

/* isu_cpu_model.sv */
// Purpose: Behavioural core facing the unit
// Assumes: Fixed short service routine
// Notes:   Bench may hold the mask set
`timescale 1ns/1ns
module isu_cpu_model (
  input  wire logic         pclk,      // Clock
  input  wire logic         presetn,   // Reset
  input  wire logic         start,     // End one instruction
  input  wire logic         trap,      // It is the trap
  input  wire logic         hold_mask, // Keep mask set
  input  wire logic [15:0]  pc,        // Next opcode
  input  isu_pkg::isu_seq_s seq,       // Commands
  output isu_pkg::isu_cpu_s cpu        // Strobes
);
  // ==========================================
  // Stack, run routine, return
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu <= '0;
      cnt <= 4'h0;
    end else begin
      cpu.instr_done <= start;
      cpu.swi_exec   <= start & trap;
      cpu.pc         <= pc;
      cpu.stack_done <= (cnt == 4'h2);
      cpu.rti_done   <= (cnt == 4'h6);
      // Mask restored at return, unless held
      cpu.i_mask     <= hold_mask | seq.set_i | (cnt != 4'h0 && cnt != 4'h6);
      if (seq.enter) cnt <= 4'h1;
      else if (cnt == 4'h6) cnt <= 4'h0;
      else if (cnt != 4'h0) cnt <= cnt + 4'h1;
    end
  end
endmodule

/* test_interrupt_sequencing_unit.sv */
// Purpose: Directed test of the sequencing unit
// Assumes: Core model paces the flow
// Notes:   Registers over APB
`timescale 1ns/1ns
module test_interrupt_sequencing_unit;
  logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic              pwrite = 1'b0, start = 1'b0, trap = 1'b0, hold_mask = 1'b0;
  logic              pready, pslverr, irq, err;
  logic [15:0]       paddr = 16'h0, pc = 16'h0;
  logic [31:0]       pwdata = 32'h0, prdata, rd;
  logic [6:1]        req_line = 6'h0, src_enable = 6'h3f;
  isu_pkg::isu_cpu_s cpu;
  isu_pkg::isu_seq_s seq;
  int                n_mismatch = 0, n_tests = 0;
  always #2 pclk = ~pclk;
  isu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_line(req_line), .src_enable(src_enable), .cpu(cpu), .seq(seq), .irq(irq));
  isu_cpu_model core (.pclk(pclk), .presetn(presetn), .start(start), .trap(trap),
    .hold_mask(hold_mask), .pc(pc), .seq(seq), .cpu(cpu));
  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    print_verdict();
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 20) hang();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_for(input int k);
    for (int i = 0; i < 60; i++) begin
      @(posedge pclk);
      if (k == 0 && seq.enter === 1'b1 || k == 1 && seq.prefetch === 1'b1
          || k == 2 && seq.fetch_next === 1'b1) return;
    end
    hang();
  endtask
  task automatic step(input logic t, input logic [15:0] p);
    @(posedge pclk);
    start <= 1'b1;
    trap  <= t;
    pc    <= p;
    @(posedge pclk);
    start <= 1'b0;
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, isu_pkg::PEND_STATUS_ONE_ADDR, 32'hff);
    apb(1'b0, isu_pkg::PEND_STATUS_ONE_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 16'hfe10, 32'h0);
    check(err, 1'b1);
    req_line <= 6'h05;
    repeat (4) @(posedge pclk);
    apb(1'b0, isu_pkg::PEND_STATUS_ONE_ADDR, 32'h0);
    check(rd, 32'h14);
    step(1'b0, 16'h1234);
    wait_for(0);
    check(seq.vector_sel, 3'h3);
    check(seq.stack_pc, 16'h1233);
    check({seq.software_trap_instruction, seq.push_h, seq.save_regs, seq.set_i}, 4'h3);
    req_line <= 6'h01;
    wait_for(1);
    check({seq.enter, seq.vector_sel}, 4'h9);
    req_line <= 6'h00;
    wait_for(1);
    check(seq.enter, 1'b0);
    hold_mask <= 1'b1;
    req_line <= 6'h02;
    step(1'b1, 16'h0400);
    wait_for(0);
    check({seq.software_trap_instruction, seq.vector_sel, seq.stack_pc}, {4'h8, 16'h0400});
    wait_for(1);
    step(1'b0, 16'h0500);
    wait_for(2);
    check(seq.enter, 1'b0);
    hold_mask <= 1'b0;
    src_enable <= 6'h3d;
    repeat (3) @(posedge pclk);
    step(1'b0, 16'h0600);
    wait_for(2);
    check(seq.enter, 1'b0);
    src_enable <= 6'h3f;
    step(1'b0, 16'h0700);
    wait_for(0);
    check(seq.vector_sel, 3'h2);
    req_line <= 6'h00;
    wait_for(1);
    check(irq, 1'b0);
    apb(1'b1, isu_pkg::EVT_MASK_ADDR, 32'h7);
    repeat (3) @(posedge pclk);
    check(irq, 1'b1);
    apb(1'b0, isu_pkg::EVT_STATUS_ADDR, 32'h0);
    check(rd, 32'h7);
    apb(1'b1, isu_pkg::EVT_STATUS_ADDR, 32'h7);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0);
    print_verdict();
  end
endmodule
